// ===== verilog/sacs_top.sv
// Serial converter sequencer: chip-select filter, shift logic, conversion timer.
// Assumes mclk is the conversion clock and io_clk idles low between accesses.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Result buffer
// ------------------------------------------------------------
module sacs_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count != (AW+1)'(D));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module sacs_top
    import sacs_pkg::*;
(
    // Conversion clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Serial link
    input wire logic io_clk,
    input wire logic cs_n,
    input wire logic addr_in,
    output logic data_out,
    output logic data_oe,
    // Mode strap
    input wire logic shared_clk,
    // Analog side
    input wire logic [sacs_pkg::RES_W-1:0] conv_code,
    output logic [sacs_pkg::ADDR_W-1:0] chan_sel,
    output logic sampling,
    output logic converting
);
    import sacs_pkg::*;

    function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
        logic [CNT_W-1:0] b;
        b[CNT_W-1] = g[CNT_W-1];
        for (int i = CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // ------------------------------------------------------------
    // Chip-select filter (mclk)
    // ------------------------------------------------------------
    logic cs_s1, cs_s2, cs_state, io_hold;
    logic [1:0] cs_cnt;
    wire cs_differs = (cs_s2 != cs_state);
    wire cs_accept = cs_differs && (cs_cnt == CS_EDGES);
    wire cs_fall_evt = cs_accept && !cs_s2;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
        end else begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
        end
    end

    // Glitches shorter than the filter never reach the link logic
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cs_state <= 1'b1;
            cs_cnt <= '0;
            io_hold <= 1'b1;
        end else begin
            cs_cnt <= (!cs_differs || cs_accept) ? 2'h0 : cs_cnt + 2'h1;
            cs_state <= cs_accept ? cs_s2 : cs_state;
            io_hold <= cs_accept ? cs_s2 : cs_state;
        end
    end

    // ------------------------------------------------------------
    // Link logic (io_clk); held clear while select is high, except the start toggle
    // ------------------------------------------------------------
    // io_hold releases while io_clk idles low, so the release is safe.
    logic [CNT_W-1:0] rise_cnt, fall_gray;
    logic [1:0] skip_r, skip_f;
    logic [ADDR_W-1:0] addr_sr, addr_cap;
    logic start_tog, link_rst;
    wire rise_skip = shared_clk && (skip_r != SKIP_EDGES);
    wire fall_skip = shared_clk && (skip_f != SKIP_EDGES);
    wire [CNT_W-1:0] fall_bin = gray2bin(fall_gray);
    wire [CNT_W-1:0] fall_next = fall_bin + 3'h1;

    always_ff @(posedge io_clk or posedge io_hold) begin
        if (io_hold) begin
            rise_cnt <= '0;
            skip_r <= '0;
            addr_sr <= '0;
        end else if (rise_skip) begin
            skip_r <= skip_r + 2'h1;
        end else begin
            if (rise_cnt < ADDR_RISES) begin
                addr_sr <= {addr_sr[ADDR_W-2:0], addr_in};
            end
            rise_cnt <= rise_cnt + 3'h1;
        end
    end

    always_ff @(negedge io_clk or posedge io_hold) begin
        if (io_hold) begin
            fall_gray <= '0;
            skip_f <= '0;
            sampling <= 1'b0;
            addr_cap <= '0;
        end else if (fall_skip) begin
            skip_f <= skip_f + 2'h1;
        end else begin
            fall_gray <= fall_next ^ (fall_next >> 1);
            if (fall_next == SAMPLE_FALL) begin
                sampling <= 1'b1;
                addr_cap <= addr_sr;
            end
            if (fall_bin == LAST_FALL) begin
                sampling <= 1'b0;
            end
        end
    end

    // Registered reset copy gives the toggle a known start value
    always_ff @(posedge mclk) begin
        link_rst <= !reset_n;
    end

    // Toggle survives io_hold so a clear never looks like a start
    always_ff @(negedge io_clk or posedge link_rst) begin
        if (link_rst) begin
            start_tog <= 1'b0;
        end else if (!io_hold && !fall_skip && fall_bin == LAST_FALL) begin
            start_tog <= ~start_tog;
        end
    end

    // ------------------------------------------------------------
    // Crossings into mclk
    // ------------------------------------------------------------
    logic [CNT_W-1:0] fg_s1, fg_s2;
    logic tg_s1, tg_s2, tg_d;
    logic [2:0] hold_pipe;
    logic [RES_W-1:0] code_s1, code_s2;
    wire [CNT_W-1:0] out_idx = gray2bin(fg_s2);
    wire start_evt = (tg_s2 != tg_d) && !io_hold && (hold_pipe == 3'h0);

    // Gray count and toggle need no frequency ratio between clocks
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            fg_s1 <= '0;
            fg_s2 <= '0;
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
            tg_d <= 1'b0;
            hold_pipe <= 3'h7;
            code_s1 <= '0;
            code_s2 <= '0;
        end else begin
            fg_s1 <= fall_gray;
            fg_s2 <= fg_s1;
            tg_s1 <= start_tog;
            tg_s2 <= tg_s1;
            tg_d <= tg_s2;
            hold_pipe <= {hold_pipe[1:0], io_hold};
            code_s1 <= conv_code;
            code_s2 <= code_s1;
        end
    end

    // ------------------------------------------------------------
    // Conversion timer; always on mclk, also in shared mode
    // ------------------------------------------------------------
    sacs_conv_e cv_state, next_cv_state;
    logic [CONV_W-1:0] cv_cnt;
    logic [RES_W-1:0] done_code, result, fifo_data;
    logic fifo_ready, fifo_valid;
    wire cv_end = (cv_state == CV_RUN) && (cv_cnt == CONV_LAST);
    wire self_test = (chan_sel == SELF_TEST_CHAN);
    wire [RES_W-1:0] next_code = self_test ? SELF_TEST_CODE : code_s2;
    wire pop = fifo_valid && (out_idx == '0);

    always_comb begin
        next_cv_state = cv_state;
        case (cv_state)
            CV_IDLE: next_cv_state = start_evt ? CV_RUN : CV_IDLE;
            CV_RUN: next_cv_state = (cv_end && !start_evt) ? CV_DONE : CV_RUN;
            CV_DONE: next_cv_state = start_evt ? CV_RUN : (fifo_ready ? CV_IDLE : CV_DONE);
            default: next_cv_state = CV_IDLE;
        endcase
        if (cs_fall_evt) begin
            next_cv_state = CV_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cv_state <= CV_IDLE;
            cv_cnt <= '0;
            chan_sel <= '0;
            done_code <= '0;
            converting <= 1'b0;
        end else begin
            cv_state <= next_cv_state;
            cv_cnt <= (start_evt || cv_state != CV_RUN) ? 6'h0 : cv_cnt + 6'h1;
            chan_sel <= start_evt ? addr_cap : chan_sel;
            done_code <= cv_end ? next_code : done_code;
            converting <= (next_cv_state == CV_RUN);
        end
    end

    sacs_fifo #(
        .W(RES_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .reset_n(reset_n),
        .in_valid(cv_state == CV_DONE),
        .in_ready(fifo_ready),
        .in_data(done_code),
        .out_valid(fifo_valid),
        .out_ready(out_idx == '0),
        .out_data(fifo_data)
    );

    // ------------------------------------------------------------
    // Result register and serial output
    // ------------------------------------------------------------
    // Loads only while the fall count is zero and a result is queued, so bits after the first fall never change
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            result <= '0;
            data_out <= 1'b0;
            data_oe <= 1'b0;
        end else begin
            result <= pop ? fifo_data : result;
            data_out <= result[RES_W-1-int'(out_idx)];
            data_oe <= !cs_state;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    output_off_a: assert property (cs_state |=> !data_oe)
        else $error("output enabled while select high");
    cs_filter_a: assert property ($changed(cs_state) |-> $past(cs_differs, 2) && $past(cs_differs, 3))
        else $error("select change accepted too early");
    msb_first_a: assert property ((!cs_state && out_idx == '0 && !pop) |=> data_out == $past(result[RES_W-1]))
        else $error("result MSB not shown");
    early_bits_a: assert property ((!cs_state && out_idx inside {[3'h1:3'h5]}) |=> data_out == $past(result[RES_W-1-int'(out_idx)]))
        else $error("wrong early result bit");
    late_bits_a: assert property ((!cs_state && out_idx inside {3'h6, 3'h7}) |=> data_out == $past(result[RES_W-1-int'(out_idx)]))
        else $error("wrong late result bit");
    conv_length_a: assert property ((cv_state == CV_RUN) ##1 (cv_state == CV_DONE) |-> $past(cv_cnt) == CONV_LAST)
        else $error("conversion not 36 cycles");
    abort_conv_a: assert property (cs_fall_evt |=> cv_state == CV_IDLE && !converting)
        else $error("select fall did not abort");
    restart_conv_a: assert property ((start_evt && !cs_fall_evt) |=> cv_state == CV_RUN && cv_cnt == 6'h0 ##1 $stable(done_code))
        else $error("new access did not restart");
    self_test_a: assert property ((cv_end && self_test) |=> done_code == SELF_TEST_CODE)
        else $error("self-test code wrong");
    load_result_a: assert property (pop |=> result == $past(fifo_data))
        else $error("result not loaded");
    addr_shift_a: assert property (@(posedge io_clk) disable iff (io_hold) (!rise_skip && rise_cnt < ADDR_RISES) |=> addr_sr[0] == $past(addr_in))
        else $error("address bit not shifted");
    skip_edges_a: assert property (@(posedge io_clk) disable iff (io_hold) rise_skip |=> $stable(addr_sr) && $stable(rise_cnt))
        else $error("address shifted during skip");
    sample_start_a: assert property (@(negedge io_clk) disable iff (io_hold) (!fall_skip && fall_next == SAMPLE_FALL) |=> sampling)
        else $error("sampling not started");
endmodule
`default_nettype wire

// ===== verilog/sacs_pkg.sv
// Constants shared by the serial converter sequencer.
// Assumes a 10 MHz conversion clock and a separate shift clock.
package sacs_pkg;
    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int RES_W = 8;
    localparam int ADDR_W = 5;
    localparam int CNT_W = 3;
    localparam int CONV_W = 6;
    localparam int FIFO_DEPTH = 4;
    localparam logic [CONV_W-1:0] CONV_LAST = 6'h23;       // 36 cycles, 0..35
    localparam logic [CNT_W-1:0] ADDR_RISES = 3'h5;
    localparam logic [CNT_W-1:0] SAMPLE_FALL = 3'h5;
    localparam logic [CNT_W-1:0] LAST_FALL = 3'h7;
    localparam logic [1:0] SKIP_EDGES = 2'h2;
    localparam logic [1:0] CS_EDGES = 2'h2;
    // ------------------------------------------------------------
    // Self-test channel
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SELF_TEST_CHAN = 5'h13;
    localparam logic [RES_W-1:0] SELF_TEST_CODE = 8'h80;
    // ------------------------------------------------------------
    // Conversion states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CV_IDLE = 3'b001,
        CV_RUN = 3'b010,
        CV_DONE = 3'b100
    } sacs_conv_e;
endpackage

// ===== verif/sacs_ctrl_model.sv
// Controller model: drives select, shift clock and address, reads results.
// Assumes mclk is the sequencer's conversion clock; shift clock idles low.
`timescale 1ns/10ps
`default_nettype none
module sacs_ctrl_model (
    // Pacing clock
    input wire logic mclk,
    // Serial link
    output logic io_clk,
    output logic cs_n,
    output logic addr_in,
    input wire logic data_out,
    input wire logic data_oe,
    input wire logic sampling
);
    initial begin
        io_clk = 1'b0;
        cs_n = 1'b1;
        addr_in = 1'b0;
    end
    // Deselected address line must not look held
    task automatic release_cs();
        @(negedge mclk);
        cs_n = 1'b1;
        addr_in = ~addr_in;
    endtask
    // Fast skips settle waits, so its result and sampling reads are not trusted; the enable read still is
    task automatic access(input logic [4:0] a, input bit fast, output logic [7:0] got,
                          output logic [2:0] smp, output bit ok);
        int n;
        got = 8'h00;
        smp = 3'h0;
        if (cs_n) begin
            @(negedge mclk);
            cs_n = 1'b0;
        end
        n = 0;
        while (data_oe !== 1'b1 && n < 30) begin
            @(negedge mclk);
            n++;
        end
        ok = (data_oe === 1'b1);
        got[7] = data_out;
        // Clean, glitch-free shift clock, held low after the eighth cycle
        for (int k = 1; k <= 8; k++) begin
            addr_in = (k <= 5) ? a[5-k] : ~addr_in;
            #32;
            io_clk = 1'b1;
            #32;
            io_clk = 1'b0;
            if (!fast) begin
                // Last fall: look before the conversion start is synced
                if (k < 8) begin
                    repeat (5) @(negedge mclk);
                end else begin
                    #2;
                end
                if (k < 8) got[7-k] = data_out;
                if (k == 4) smp[0] = sampling;
                if (k == 5) smp[1] = sampling;
                if (k == 8) smp[2] = sampling;
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_serial_adc_conversion_sequencer.sv
// Testbench for the serial converter sequencer, with a controller model.
// Assumes a 10 MHz mclk and the shared-clock strap left low.
`timescale 1ns/10ps
`default_nettype none
module tb_serial_adc_conversion_sequencer;
    import sacs_pkg::*;
    logic mclk, reset_n, io_clk, cs_n, addr_in, data_out, data_oe, shared_clk;
    logic sampling, converting;
    logic [RES_W-1:0] conv_code;
    logic [ADDR_W-1:0] chan_sel;
    int fails, total_checks, n;
    sacs_top dut (.mclk(mclk), .reset_n(reset_n), .io_clk(io_clk), .cs_n(cs_n),
        .addr_in(addr_in), .data_out(data_out), .data_oe(data_oe),
        .shared_clk(shared_clk), .conv_code(conv_code), .chan_sel(chan_sel),
        .sampling(sampling), .converting(converting));
    sacs_ctrl_model u_ctrl (.mclk(mclk), .io_clk(io_clk), .cs_n(cs_n), .addr_in(addr_in),
        .data_out(data_out), .data_oe(data_oe), .sampling(sampling));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wait_conv(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (converting !== lvl && cnt < lim) begin
            @(negedge mclk);
            cnt++;
        end
        if (cnt == lim) begin
            fails++;
            $display("[ERR] t=%0t wait for converting %h timed out", $time, lvl);
            complete_run();
        end
    endtask
    task automatic do_access(input logic [4:0] a, input bit fast, input logic [7:0] exp);
        logic [7:0] got;
        logic [2:0] smp;
        bit ok;
        u_ctrl.access(a, fast, got, smp, ok);
        check("enable", 8'(ok), 8'h01);
        if (!ok) complete_run();
        if (!fast) begin
            check("result", got, exp);
            check("sampling", 8'(smp), 8'h02);
        end
    endtask
    task automatic run_conv(input logic [4:0] a);
        wait_conv(1'b1, 10, n);
        wait_conv(1'b0, 60, n);
        check("conv length", 8'(n), 8'h24);
        check("channel", 8'(chan_sel), 8'(a));
        repeat (10) @(negedge mclk);
    endtask
    task automatic t_first();
        check("idle enable", 8'(data_oe), 8'h00);
        conv_code = 8'h5A;
        do_access(5'h03, 1'b1, 8'h00);
        run_conv(5'h03);
        u_ctrl.release_cs();
        repeat (10) @(negedge mclk);
        check("off enable", 8'(data_oe), 8'h00);
        $display("done: first access");
    endtask
    task automatic t_back_to_back();
        conv_code = 8'hA5;
        do_access(5'h0C, 1'b0, 8'h5A);
        run_conv(5'h0C);
        do_access(SELF_TEST_CHAN, 1'b0, 8'hA5);
        run_conv(SELF_TEST_CHAN);
        do_access(5'h01, 1'b0, SELF_TEST_CODE);
        $display("done: back to back");
    endtask
    task automatic t_abort();
        conv_code = 8'h3C;
        wait_conv(1'b1, 10, n);
        // Select raised mid-conversion and dropped again on purpose
        u_ctrl.release_cs();
        repeat (8) @(negedge mclk);
        fork
            do_access(5'h02, 1'b0, SELF_TEST_CODE);
            begin
                repeat (10) @(negedge mclk);
                check("aborted", 8'(converting), 8'h00);
            end
        join
        run_conv(5'h02);
        $display("done: abort");
    endtask
    task automatic t_restart();
        conv_code = 8'hC3;
        do_access(5'h05, 1'b0, 8'h3C);
        do_access(5'h06, 1'b1, 8'h00);
        wait_conv(1'b0, 60, n);
        check("restarted", 8'(n >= 33 && n <= 40), 8'h01);
        repeat (10) @(negedge mclk);
        do_access(5'h07, 1'b0, 8'hC3);
        run_conv(5'h07);
        u_ctrl.release_cs();
        $display("done: restart");
    endtask
    initial begin
        fails = 0;
        total_checks = 0;
        reset_n = 1'b0;
        shared_clk = 1'b0;
        conv_code = 8'h00;
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        repeat (2) @(negedge mclk);
        t_first();
        t_back_to_back();
        t_abort();
        t_restart();
        complete_run();
    end
endmodule
`default_nettype wire
